// file: common/cpd_pkg.sv
package cpd_pkg;

    // ------------------------------------------------------------
    // Process image layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int CODE_W = 6;
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 10;
    localparam int ERR_BIT = 15;
    localparam int GATE_BIT = 9;
    localparam int OUT_BIT = 8;
    localparam int PARAM0_W = 10;
    localparam int CMD_PARAM_W = 26;
    localparam int RESULT_W = 24;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [5:0] CMD_READ = 6'h00;
    localparam logic [5:0] CMD_FREQ = 6'h04;
    localparam logic [5:0] CMD_EVENT = 6'h05;
    localparam logic [5:0] CMD_TIME = 6'h06;
    localparam logic [5:0] CMD_PULSE = 6'h07;
    localparam logic [5:0] CMD_STOP = 6'h08;
    localparam logic [5:0] CMD_START = 6'h09;
    localparam logic [5:0] CMD_DEFAULT = 6'h0A;
    localparam logic [5:0] CMD_SYSSET = 6'h0C;
    localparam logic [5:0] CMD_VERSION = 6'h0F;
    localparam logic [5:0] CMD_INITVAL = 6'h10;
    localparam logic [5:0] CMD_FINALVAL = 6'h14;

    // ------------------------------------------------------------
    // Frequency parameter limits
    // ------------------------------------------------------------
    localparam logic [9:0] FREQ_FACTOR_MIN = 10'h001;
    localparam logic [9:0] FREQ_FACTOR_MAX = 10'h3E8;
    localparam logic [9:0] FREQ_GATE_MIN = 10'h3FC;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] IN_WORD0_RST = 16'h8000;
    localparam logic [15:0] IN_WORD1_RST = 16'h0000;
    localparam logic [5:0] CMD_CODE_RST = 6'h00;
    localparam logic [25:0] CMD_PARAM_RST = 26'h000_0000;

    typedef enum logic [2:0] {
        MODE_NONE = 3'b000,
        MODE_FREQ = 3'b001,
        MODE_EVENT = 3'b010,
        MODE_TIME = 3'b011,
        MODE_PULSE = 3'b100
    } cpd_mode_type;

endpackage

// file: common/cpd_cmd_if.sv
`timescale 1ns/100ps
interface cpd_cmd_if;
    logic [5:0] code;
    logic [9:0] param0;
    logic is_read;
    logic is_mode;
    logic is_start;
    logic is_stop;
    logic uses_word1;
    logic is_version;
    logic reserved;
    logic param_bad;

    modport dec (
        input code,
        input param0,
        output is_read,
        output is_mode,
        output is_start,
        output is_stop,
        output uses_word1,
        output is_version,
        output reserved,
        output param_bad
    );

    modport core (
        output code,
        output param0,
        input is_read,
        input is_mode,
        input is_start,
        input is_stop,
        input uses_word1,
        input is_version,
        input reserved,
        input param_bad
    );
endinterface

// file: rtl/cpd_cmd_decode.sv
`timescale 1ns/100ps
module cpd_cmd_decode (
    cpd_cmd_if.dec bus // Command fields in, class flags out
);
    import cpd_pkg::*;

    // ------------------------------------------------------------
    // Command classification
    // ------------------------------------------------------------
    always_comb begin
        bus.is_read = 1'b0;
        bus.is_mode = 1'b0;
        bus.is_start = 1'b0;
        bus.is_stop = 1'b0;
        bus.uses_word1 = 1'b0;
        bus.is_version = 1'b0;
        bus.reserved = 1'b0;
        bus.param_bad = 1'b0;
        // Parameter bits matter only for commands that take them
        unique case (bus.code)
            CMD_READ: bus.is_read = 1'b1;
            CMD_FREQ: begin
                bus.is_mode = 1'b1;
                bus.param_bad = !(((bus.param0 >= FREQ_FACTOR_MIN) &&
                                  (bus.param0 <= FREQ_FACTOR_MAX)) ||
                                  (bus.param0 >= FREQ_GATE_MIN));
            end
            CMD_EVENT, CMD_TIME, CMD_PULSE: begin
                bus.is_mode = 1'b1;
                bus.uses_word1 = 1'b1;
            end
            CMD_STOP: bus.is_stop = 1'b1;
            CMD_START: bus.is_start = 1'b1;
            CMD_DEFAULT: ;
            CMD_SYSSET, CMD_INITVAL, CMD_FINALVAL: bus.uses_word1 = 1'b1;
            CMD_VERSION: bus.is_version = 1'b1;
            default: bus.reserved = 1'b1;
        endcase
    end

endmodule

// file: rtl/cpd_core.sv
`timescale 1ns/100ps
// Overview of operation
// - The image is two 16-bit words in each direction.
// - Commands and parameters in the output words steer the terminal.
// - Parameter bits of commands without parameters are ignored.
// - Non-read commands are echoed into the input words in place.
// - Input word 1 need not mirror an unused output word 1.
// - Bit 15 flags no setup, bad value, modeless read or reserved code.
// - After a read, bits 14 to 10 of word 0 are zero and bit 15 is the error flag.
// - After a read, bit 9 of word 0 shows the gate input level.
// - After a read, bit 8 of word 0 shows the output or relation state.
// - Time mode returns 16 bits in word 1 and clears word 0 bits 7 to 0.
// - Frequency and event modes put a 24-bit result across both words.
// - The command code sits in bits 15 to 10 of output word 0.
module cpd_core #(
    parameter int COUNT_W = 24,
    parameter logic [15:0] FW_VERSION = 16'h0001 // Arbitrary value
) (
    input wire logic clk_i, // 25 MHz clock
    input wire logic rst_i, // Async reset, active high
    input wire logic xfer_i, // One-cycle exchange strobe
    input wire logic [15:0] out_word0_i, // Command word from controller
    input wire logic [15:0] out_word1_i, // Parameter word from controller
    input wire logic gate_i, // Gate control input level
    input wire logic out_state_i, // Output or relation state
    input wire logic [COUNT_W-1:0] count_i, // Current count result
    output logic [15:0] in_word0_o, // Status and result high word
    output logic [15:0] in_word1_o, // Result low word
    output cpd_pkg::cpd_mode_type mode_o, // Selected operating mode
    output logic run_o, // Counter running
    output logic cmd_strobe_o, // Accepted command pulse
    output logic [5:0] cmd_code_o, // Accepted command code
    output logic [25:0] cmd_param_o // Accepted 26-bit parameter
);
    import cpd_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (COUNT_W != RESULT_W) begin : g_bad_width
            $error("COUNT_W must be 24");
        end
    endgenerate

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    cpd_cmd_if dec_bus ();

    // Both words are taken in the same strobe cycle
    assign dec_bus.code = out_word0_i[CODE_MSB:CODE_LSB];
    assign dec_bus.param0 = out_word0_i[PARAM0_W-1:0];

    cpd_cmd_decode u_dec (
        .bus(dec_bus)
    );

    logic cmd_err;
    logic cmd_ok;

    cpd_mode_type mode_reg;
    cpd_mode_type mode_next;
    logic run_reg;
    logic run_next;

    always_comb begin
        cmd_err = dec_bus.reserved || dec_bus.param_bad ||
                  (dec_bus.is_read && (mode_reg == MODE_NONE));
        cmd_ok = xfer_i && !cmd_err;
    end

    // ------------------------------------------------------------
    // Mode and run state
    // ------------------------------------------------------------
    always_comb begin
        mode_next = mode_reg;
        run_next = run_reg;
        if (cmd_ok) begin
            if (dec_bus.is_mode) begin
                run_next = 1'b1;
                unique case (dec_bus.code)
                    CMD_FREQ: mode_next = MODE_FREQ;
                    CMD_EVENT: mode_next = MODE_EVENT;
                    CMD_TIME: mode_next = MODE_TIME;
                    default: mode_next = MODE_PULSE;
                endcase
            end else if (dec_bus.is_stop) begin
                run_next = 1'b0;
            end else if (dec_bus.is_start && (mode_reg != MODE_NONE)) begin
                run_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= MODE_NONE;
            run_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            run_reg <= run_next;
        end
    end

    // ------------------------------------------------------------
    // Input image
    // ------------------------------------------------------------
    logic [15:0] in0_reg;
    logic [15:0] in0_next;
    logic [15:0] in1_reg;
    logic [15:0] in1_next;

    always_comb begin
        in0_next = in0_reg;
        in1_next = in1_reg;
        if (xfer_i) begin
            if (dec_bus.is_read) begin
                in0_next = 16'h0000;
                in1_next = 16'h0000;
                in0_next[GATE_BIT] = gate_i;
                in0_next[OUT_BIT] = out_state_i;
                unique case (mode_reg)
                    MODE_TIME: in1_next = count_i[15:0];
                    MODE_FREQ, MODE_EVENT, MODE_PULSE: begin
                        in0_next[7:0] = count_i[COUNT_W-1 -: 8];
                        in1_next = count_i[15:0];
                    end
                    MODE_NONE: in1_next = 16'h0000;
                    default: in1_next = 16'h0000;
                endcase
            end else begin
                in0_next = out_word0_i;
                if (dec_bus.uses_word1) begin
                    in1_next = out_word1_i;
                end else if (dec_bus.is_version) begin
                    in1_next = FW_VERSION;
                end else begin
                    in1_next = 16'h0000;
                end
            end
            in0_next[ERR_BIT] = cmd_err;
        end
    end

    // Reset image carries the error bit: not yet configured
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in0_reg <= IN_WORD0_RST;
            in1_reg <= IN_WORD1_RST;
        end else begin
            in0_reg <= in0_next;
            in1_reg <= in1_next;
        end
    end

    // ------------------------------------------------------------
    // Command hand-off to the counting core
    // ------------------------------------------------------------
    logic strobe_reg;
    logic strobe_next;
    logic [5:0] code_reg;
    logic [5:0] code_next;
    logic [25:0] param_reg;
    logic [25:0] param_next;

    always_comb begin
        strobe_next = cmd_ok && !dec_bus.is_read;
        code_next = code_reg;
        param_next = param_reg;
        if (strobe_next) begin
            code_next = dec_bus.code;
            param_next = {dec_bus.param0, out_word1_i};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strobe_reg <= 1'b0;
            code_reg <= CMD_CODE_RST;
            param_reg <= CMD_PARAM_RST;
        end else begin
            strobe_reg <= strobe_next;
            code_reg <= code_next;
            param_reg <= param_next;
        end
    end

    assign in_word0_o = in0_reg;
    assign in_word1_o = in1_reg;
    assign mode_o = mode_reg;
    assign run_o = run_reg;
    assign cmd_strobe_o = strobe_reg;
    assign cmd_code_o = code_reg;
    assign cmd_param_o = param_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    echo_word0_a: assert property (
        xfer_i && (out_word0_i[15:10] != CMD_READ) |=>
            in_word0_o[14:0] == $past(out_word0_i[14:0]))
        else $error("command word not echoed");

    unused_word1_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_STOP) |=>
            in_word1_o == 16'h0000)
        else $error("unused word 1 not cleared");

    ignore_param_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_STOP) |=>
            !in_word0_o[15] && !run_o)
        else $error("stop parameters not ignored");

    read_nomode_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_READ) &&
            (mode_o == MODE_NONE) |=> in_word0_o[15])
        else $error("read without mode not flagged");

    reserved_err_a: assert property (
        xfer_i && (out_word0_i[15:10] == 6'h3F) |=>
            in_word0_o[15] && !cmd_strobe_o)
        else $error("reserved code not flagged");

    read_status_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_READ) |=>
            (in_word0_o[14:10] == 5'h00) &&
            (in_word0_o[9] == $past(gate_i)) &&
            (in_word0_o[8] == $past(out_state_i)))
        else $error("read status bits wrong");

    time_result_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_READ) &&
            (mode_o == MODE_TIME) |=>
            (in_word0_o[7:0] == 8'h00) &&
            (in_word1_o == $past(count_i[15:0])))
        else $error("time result misplaced");

    wide_result_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_READ) &&
            ((mode_o == MODE_FREQ) || (mode_o == MODE_EVENT)) |=>
            ({in_word0_o[7:0], in_word1_o} == $past(count_i)))
        else $error("24-bit result misplaced");

    image_hold_a: assert property (
        !xfer_i |=> $stable(in_word0_o) && $stable(in_word1_o))
        else $error("image changed without exchange");

    mode_set_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_TIME) |=>
            (mode_o == MODE_TIME) && run_o && cmd_strobe_o ##1
            !cmd_strobe_o || $past(xfer_i))
        else $error("mode command not applied");

    freq_param_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_FREQ) &&
            ((out_word0_i[9:0] == 10'h000) ||
            ((out_word0_i[9:0] > FREQ_FACTOR_MAX) &&
            (out_word0_i[9:0] < FREQ_GATE_MIN))) |=>
            in_word0_o[15] && !cmd_strobe_o &&
            (mode_o == $past(mode_o)))
        else $error("bad frequency factor accepted");

    freq_mode_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_FREQ) &&
            (out_word0_i[9:0] == 10'h001) |=>
            (mode_o == MODE_FREQ) && run_o && !in_word0_o[15])
        else $error("valid frequency mode not applied");

    cmd_handoff_a: assert property (
        cmd_strobe_o |->
            (cmd_code_o == $past(out_word0_i[15:10])) &&
            (cmd_param_o == {$past(out_word0_i[9:0]), $past(out_word1_i)}))
        else $error("accepted command not handed off");

    start_nomode_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_START) &&
            (mode_o == MODE_NONE) |=> !run_o)
        else $error("start ran without a mode");

    read_nostrobe_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_READ) |=>
            !cmd_strobe_o && $stable(cmd_code_o))
        else $error("count read handed off as command");

    version_word_a: assert property (
        xfer_i && (out_word0_i[15:10] == CMD_VERSION) |=>
            (in_word1_o == FW_VERSION) && !in_word0_o[15])
        else $error("version word wrong");

    read_freq_c: cover property (
        xfer_i && (out_word0_i[15:10] == CMD_READ) &&
        (mode_o == MODE_FREQ));
    bad_param_c: cover property (
        xfer_i && (out_word0_i[15:10] == CMD_FREQ) &&
        (out_word0_i[9:0] == 10'h3F0));
    stop_start_c: cover property (
        run_o ##1 !run_o [*2] ##1 run_o);
    version_c: cover property (
        xfer_i && (out_word0_i[15:10] == CMD_VERSION));

endmodule

// file: testbench/cpd_ctrl_model.sv
`timescale 1ns/100ps
module cpd_ctrl_model (
    input wire logic clk_i, // Exchange clock
    output logic xfer_o, // Exchange strobe
    output logic [15:0] word0_o, // Command word to the terminal
    output logic [15:0] word1_o // Parameter word to the terminal
);
    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    initial begin
        xfer_o = 1'b0;
        word0_o = 16'h0000;
        word1_o = 16'hffff;
    end

    // ------------------------------------------------------------
    // One exchange: both words change together and hold for the edge
    // ------------------------------------------------------------
    task automatic exchange(input logic [15:0] w0, input logic [15:0] w1);
        xfer_o = 1'b1;
        word0_o = w0;
        word1_o = w1;
        @(posedge clk_i);
        #1;
    endtask

    // Between exchanges the words are inverted each cycle, so two idles in a row bring back the last command
    task automatic idle();
        xfer_o = 1'b0;
        word0_o = ~word0_o;
        word1_o = ~word1_o;
        @(posedge clk_i);
        #1;
    endtask
endmodule

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    import cpd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic gate_i = 1'b0;
    logic out_state_i = 1'b0;
    logic [23:0] count_i = 24'h00_0000;
    logic xfer;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] a;
    logic [15:0] in_word0_o;
    logic [15:0] in_word1_o;
    cpd_mode_type mode_o;
    logic run_o;
    logic cmd_strobe_o;
    logic [5:0] cmd_code_o;
    logic [25:0] cmd_param_o;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int m_mode = 0;
    int m_run = 0;
    int m_code = 0;
    int m_param = 0;
    logic [9:0] fp[$] = '{10'h000, 10'h001, 10'h3e8, 10'h3e9, 10'h3fb,
                         10'h3fc, 10'h3ff};

    always #20 clk_i = ~clk_i;

    cpd_ctrl_model cpd_ctrl_model_i (
        .clk_i(clk_i),
        .xfer_o(xfer),
        .word0_o(w0),
        .word1_o(w1)
    );

    cpd_core cpd_core_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .xfer_i(xfer),
        .out_word0_i(w0),
        .out_word1_i(w1),
        .gate_i(gate_i),
        .out_state_i(out_state_i),
        .count_i(count_i),
        .in_word0_o(in_word0_o),
        .in_word1_o(in_word1_o),
        .mode_o(mode_o),
        .run_o(run_o),
        .cmd_strobe_o(cmd_strobe_o),
        .cmd_code_o(cmd_code_o),
        .cmd_param_o(cmd_param_o)
    );

    // ------------------------------------------------------------
    // Compare and report
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_word(input logic [25:0] got, input logic [25:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Reference model of one exchange
    // ------------------------------------------------------------
    task automatic send(input logic [15:0] cw, input logic [15:0] pw);
        int c;
        int p;
        bit err;
        bit acc;
        logic [15:0] e0;
        logic [15:0] e1;
        gate_i = 1'($urandom);
        out_state_i = 1'($urandom);
        count_i = 24'($urandom);
        c = int'(cw[15:10]);
        p = int'(cw[9:0]);
        e0 = {1'b0, cw[14:0]};
        e1 = 16'h0000;
        acc = 1'b0;
        if (c == 0) begin
            err = (m_mode == 0);
            e0 = {6'h00, gate_i, out_state_i, count_i[23:16]};
            if (m_mode == 3) e0[7:0] = 8'h00;
            e1 = count_i[15:0];
        end else begin
            err = !(c inside {4, 5, 6, 7, 8, 9, 10, 12, 15, 16, 20}) ||
                (c == 4 && (p == 0 || (p > 1000 && p < 1020)));
            acc = !err;
            e0[15] = err;
            if (c inside {5, 6, 7, 12, 16, 20}) e1 = pw;
            if (c == 15) e1 = 16'h0001;
        end
        if (acc) begin
            m_code = c;
            m_param = int'({cw[9:0], pw});
            if (c >= 4 && c <= 7) begin
                m_mode = c - 3;
                m_run = 1;
            end
            if (c == 8) m_run = 0;
            if (c == 9 && m_mode != 0) m_run = 1;
        end
        cpd_ctrl_model_i.exchange(cw, pw);
        check_flag(in_word0_o[15], err);
        if (c != 0 || !err) check_word(26'(in_word0_o), 26'(e0));
        if (!err) check_word(26'(in_word1_o), 26'(e1));
        check_flag(cmd_strobe_o, acc);
        check_word(26'(mode_o), 26'(m_mode));
        check_flag(run_o, m_run != 0);
        check_word(26'(cmd_code_o), 26'(m_code));
        check_word(cmd_param_o, 26'(m_param));
    endtask

    task automatic gap();
        logic [15:0] h0;
        logic [15:0] h1;
        h0 = in_word0_o;
        h1 = in_word1_o;
        cpd_ctrl_model_i.idle();
        check_word(26'(in_word0_o), 26'(h0));
        check_word(26'(in_word1_o), 26'(h1));
        check_flag(cmd_strobe_o, 1'b0);
    endtask

    task automatic do_reset(input int n);
        rst_i = 1'b1;
        repeat (n) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        m_mode = 0;
        m_run = 0;
        m_code = 0;
        m_param = 0;
        check_word(26'(in_word0_o), 26'(16'h8000));
        check_word(26'(in_word1_o), 26'h000_0000);
        check_word(26'(mode_o), 26'h000_0000);
        check_word(cmd_param_o, 26'h000_0000);
        check_flag(cmd_strobe_o, 1'b0);
        check_flag(run_o, 1'b0);
        check_word(26'(cmd_code_o), 26'h000_0000);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h39f39ba7));
        do_reset(12);
        send({6'h00, 10'($urandom)}, 16'($urandom));
        for (int c = 1; c < 64; c++) begin
            if (c < 4 || c > 7) begin
                send({6'(c), 10'($urandom)}, 16'($urandom));
            end
            if (c % 8 == 0) gap();
        end
        foreach (fp[i]) begin
            send({6'h04, fp[i]}, 16'($urandom));
            send({6'h00, 10'($urandom)}, 16'($urandom));
        end
        for (int m = 4; m < 8; m++) begin
            send({6'(m), 10'h00a}, 16'($urandom));
            send({6'h00, 10'($urandom)}, 16'($urandom));
            send({6'h08, 10'($urandom)}, 16'($urandom));
            send({6'h09, 10'($urandom)}, 16'($urandom));
            send({6'h00, 10'($urandom)}, 16'($urandom));
            gap();
        end
        gap();
        do_reset(2);
        send(16'h0000, 16'h0000);
        for (int i = 0; i < 300; i++) begin
            a = 16'($urandom);
            if (i % 3 == 0) a[15:10] = 6'h00;
            send(a, 16'($urandom));
            if (i % 50 == 0) gap();
        end
        report_and_stop();
    end
endmodule
